// [psr_masked_reg.sv]
// Purpose: one reset control register with capability-gated writes
// Assumes: write data already merged with byte enables by the caller
// Notes: bits outside IMPL or cleared in cap_mask never store a one
`timescale 1ns/1ns
module psr_masked_reg #(
	parameter int WIDTH = 32,
	parameter logic [31:0] IMPL = 32'hFFFF_FFFF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [WIDTH-1:0] cap_mask,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] value_reg;
	logic [WIDTH-1:0] value_next;
	logic [WIDTH-1:0] impl_bits;

	initial begin
		if (WIDTH < 1 || WIDTH > 32) begin
			$error("psr_masked_reg: WIDTH must be 1 to 32");
		end
	end

	assign impl_bits = IMPL[WIDTH-1:0];
	// absent units and reserved bits stay zero
	assign value_next = wr_en ? (wr_data & cap_mask & impl_bits) : value_reg;
	assign value = value_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= psr_pkg::PSR_RESET_VALUE[WIDTH-1:0];
		end else begin
			value_reg <= value_next;
		end
	end
endmodule : psr_masked_reg

// [psr_pkg.sv]
// Purpose: shared constants for the peripheral soft reset control block
// Assumes: 32-bit apb data, 12-bit byte offsets inside the system control space
// Notes: offsets are byte addresses; field positions are bit indices
package psr_pkg;
	localparam int PSR_ADDR_W = 12;
	localparam int PSR_DATA_W = 32;
	localparam int PSR_STRB_W = 4;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [11:0] PSR_PERIPH_RESET_OFF = 12'h044;
	localparam logic [11:0] PSR_PORT_RESET_OFF = 12'h048;
	localparam logic [11:0] PSR_PERIPH_STATUS_OFF = 12'h050;
	localparam logic [11:0] PSR_PORT_STATUS_OFF = 12'h054;

	// ************************************************************
	// reset values and implemented bits
	// ************************************************************
	localparam logic [31:0] PSR_RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] PSR_PERIPH_IMPL = 32'h0307_0011;
	localparam logic [31:0] PSR_PORT_IMPL = 32'h0000_00FF;
	localparam logic [31:0] PSR_READ_IDLE = 32'h0000_0000;

	// ************************************************************
	// field positions in peripheral_reset_ctrl_a
	// ************************************************************
	localparam int PSR_COMPARATOR_ONE_RESET_BIT = 25;
	localparam int PSR_COMPARATOR_ZERO_RESET_BIT = 24;
	localparam int PSR_GP_COUNTER_TWO_RESET_BIT = 18;
	localparam int PSR_GP_COUNTER_ONE_RESET_BIT = 17;
	localparam int PSR_GP_COUNTER_ZERO_RESET_BIT = 16;
	localparam int PSR_SYNC0_BIT = 4;
	localparam int PSR_ASYNC0_BIT = 0;

	// ************************************************************
	// field positions in port_reset_ctrl
	// ************************************************************
	localparam int PSR_PORT_A_BIT = 0;
	localparam int PSR_PORT_COUNT = 8;

	// ************************************************************
	// apb access phases
	// ************************************************************
	typedef enum logic [2:0] {
		PSR_PH_IDLE = 3'h1,
		PSR_PH_SETUP = 3'h2,
		PSR_PH_ACCESS = 3'h4
	} psr_phase_e;
endpackage : psr_pkg

// [psr_reset_ctrl.sv]
// Purpose: software peripheral reset control behind an apb slave port
// Assumes: capability masks come from logic on pclk; zero-wait apb
// Notes: peripheral reset outputs are active high and come from flops
`timescale 1ns/1ns

// What this block does
// [R1] peripheral register writes gated by capability two
// [R2] port register writes gated by capability four
// [R3] bits 25 and 24 reset comparators
// [R4] bits 18 to 16 reset timers
// [R5] bit 4 resets synchronous serial unit
// [R6] bit 0 resets asynchronous serial unit
// [R7] port bits 0 to 7 reset ports
// [R8] both registers clear to zero on reset
// [R9] reserved bits read-only, read zero
// [R10] set bit holds reset, clear releases
module psr_reset_ctrl #(
	parameter int PORT_COUNT = psr_pkg::PSR_PORT_COUNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [psr_pkg::PSR_ADDR_W-1:0] paddr,
	input wire logic [psr_pkg::PSR_DATA_W-1:0] pwdata,
	input wire logic [psr_pkg::PSR_STRB_W-1:0] pstrb,
	output logic [psr_pkg::PSR_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] capability_mask_two,
	input wire logic [31:0] capability_mask_four,
	output logic comparator_one_reset,
	output logic comparator_zero_reset,
	output logic gp_counter_two_reset,
	output logic gp_counter_one_reset,
	output logic gp_counter_zero_reset,
	output logic sync_serial_zero_reset,
	output logic async_serial_zero_reset,
	output logic io_port_a_reset,
	output logic io_port_b_reset,
	output logic io_port_c_reset,
	output logic io_port_d_reset,
	output logic io_port_e_reset,
	output logic io_port_f_reset,
	output logic io_port_g_reset,
	output logic io_port_h_reset
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	initial begin
		if (PORT_COUNT != psr_pkg::PSR_PORT_COUNT) begin
			$error("psr_reset_ctrl: PORT_COUNT must equal the eight port outputs");
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] strb_to_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : strb_to_mask

	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = strb_to_mask(strb);
		return (new_val & m) | (old_val & ~m);
	endfunction : merge_bytes

	function automatic logic addr_hit(
		input logic [psr_pkg::PSR_ADDR_W-1:0] a,
		input logic [11:0] off
	);
		return a == off;
	endfunction : addr_hit

	// unit order inside the request vector: comparator_one_reset, comparator_zero_reset, gp_counter_two_reset..0, sync0, async0
	function automatic logic [31:0] periph_place(input logic [6:0] u);
		logic [31:0] v;
		v = psr_pkg::PSR_READ_IDLE;
		v[psr_pkg::PSR_COMPARATOR_ONE_RESET_BIT] = u[6];
		v[psr_pkg::PSR_COMPARATOR_ZERO_RESET_BIT] = u[5];
		v[psr_pkg::PSR_GP_COUNTER_TWO_RESET_BIT] = u[4];
		v[psr_pkg::PSR_GP_COUNTER_ONE_RESET_BIT] = u[3];
		v[psr_pkg::PSR_GP_COUNTER_ZERO_RESET_BIT] = u[2];
		v[psr_pkg::PSR_SYNC0_BIT] = u[1];
		v[psr_pkg::PSR_ASYNC0_BIT] = u[0];
		return v;
	endfunction : periph_place

	function automatic logic [31:0] port_place(input logic [psr_pkg::PSR_PORT_COUNT-1:0] p);
		logic [31:0] v;
		v = psr_pkg::PSR_READ_IDLE;
		v[psr_pkg::PSR_PORT_A_BIT +: psr_pkg::PSR_PORT_COUNT] = p;
		return v;
	endfunction : port_place

	// ************************************************************
	// package consistency checks
	// ************************************************************
	// a stray field position would tie a unit to a bit that never stores a one
	initial begin
		if (periph_place('1) != psr_pkg::PSR_PERIPH_IMPL) begin
			$error("psr_reset_ctrl: peripheral fields disagree with implemented bits");
		end
		if (port_place('1) != psr_pkg::PSR_PORT_IMPL) begin
			$error("psr_reset_ctrl: port fields disagree with implemented bits");
		end
		if (psr_pkg::PSR_PORT_A_BIT + PORT_COUNT > psr_pkg::PSR_DATA_W) begin
			$error("psr_reset_ctrl: port field does not fit the data word");
		end
		if (psr_pkg::PSR_STRB_W * 8 != psr_pkg::PSR_DATA_W) begin
			$error("psr_reset_ctrl: one strobe per data byte expected");
		end
		if (psr_pkg::PSR_ADDR_W != $bits(psr_pkg::PSR_PERIPH_RESET_OFF)) begin
			$error("psr_reset_ctrl: address width must match the offsets");
		end
		if (psr_pkg::PSR_PERIPH_RESET_OFF[1:0] != 2'h0) begin
			$error("psr_reset_ctrl: peripheral control offset not word aligned");
		end
		if (psr_pkg::PSR_PORT_RESET_OFF[1:0] != 2'h0) begin
			$error("psr_reset_ctrl: port control offset not word aligned");
		end
		if (psr_pkg::PSR_PERIPH_STATUS_OFF[1:0] != 2'h0) begin
			$error("psr_reset_ctrl: peripheral status offset not word aligned");
		end
		if (psr_pkg::PSR_PORT_STATUS_OFF[1:0] != 2'h0) begin
			$error("psr_reset_ctrl: port status offset not word aligned");
		end
		if (psr_pkg::PSR_PERIPH_RESET_OFF == psr_pkg::PSR_PORT_RESET_OFF) begin
			$error("psr_reset_ctrl: control offsets must differ");
		end
		if (psr_pkg::PSR_PERIPH_STATUS_OFF == psr_pkg::PSR_PORT_STATUS_OFF) begin
			$error("psr_reset_ctrl: status offsets must differ");
		end
		if (psr_pkg::PSR_PERIPH_STATUS_OFF == psr_pkg::PSR_PERIPH_RESET_OFF) begin
			$error("psr_reset_ctrl: peripheral status overlaps its control");
		end
		if (psr_pkg::PSR_PORT_STATUS_OFF == psr_pkg::PSR_PORT_RESET_OFF) begin
			$error("psr_reset_ctrl: port status overlaps its control");
		end
		if (psr_pkg::PSR_RESET_VALUE != 32'h0000_0000) begin
			$error("psr_reset_ctrl: both registers must clear to zero");
		end
	end

	// ************************************************************
	// apb phase tracking
	// ************************************************************
	psr_pkg::psr_phase_e phase_reg;
	psr_pkg::psr_phase_e phase_next;

	wire setup_phase = psel & ~penable;
	wire access_phase = psel & penable;

	always_comb begin
		case (phase_reg)
			psr_pkg::PSR_PH_IDLE: begin
				phase_next = setup_phase ? psr_pkg::PSR_PH_SETUP : psr_pkg::PSR_PH_IDLE;
			end
			psr_pkg::PSR_PH_SETUP: begin
				phase_next = access_phase ? psr_pkg::PSR_PH_ACCESS : psr_pkg::PSR_PH_IDLE;
			end
			psr_pkg::PSR_PH_ACCESS: begin
				phase_next = setup_phase ? psr_pkg::PSR_PH_SETUP : psr_pkg::PSR_PH_IDLE;
			end
			default: begin
				phase_next = psr_pkg::PSR_PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= psr_pkg::PSR_PH_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// ************************************************************
	// address decode
	// ************************************************************
	wire hit_periph = addr_hit(paddr, psr_pkg::PSR_PERIPH_RESET_OFF);
	wire hit_port = addr_hit(paddr, psr_pkg::PSR_PORT_RESET_OFF);
	wire hit_periph_stat = addr_hit(paddr, psr_pkg::PSR_PERIPH_STATUS_OFF);
	wire hit_port_stat = addr_hit(paddr, psr_pkg::PSR_PORT_STATUS_OFF);
	wire hit_any = hit_periph | hit_port | hit_periph_stat | hit_port_stat;

	// a write needs its setup cycle right before the access cycle
	wire first_access = access_phase & (phase_reg == psr_pkg::PSR_PH_SETUP);
	// writes take effect at the access edge only
	wire wr_access = first_access & pwrite & pready;
	wire wr_periph = wr_access & hit_periph;
	wire wr_port = wr_access & hit_port;

	// ************************************************************
	// control registers
	// ************************************************************
	logic [31:0] periph_ctrl;
	logic [31:0] port_ctrl;
	logic [31:0] periph_wdata;
	logic [31:0] port_wdata;

	// untouched byte lanes keep their stored value
	assign periph_wdata = merge_bytes(periph_ctrl, pwdata, pstrb);
	assign port_wdata = merge_bytes(port_ctrl, pwdata, pstrb);

	psr_masked_reg #(
		.WIDTH(32),
		.IMPL(psr_pkg::PSR_PERIPH_IMPL)
	) u_periph_reg (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_periph),
		.wr_data(periph_wdata),
		.cap_mask(capability_mask_two), // [R1] [R9] [R8]
		.value(periph_ctrl)
	);

	psr_masked_reg #(
		.WIDTH(32),
		.IMPL(psr_pkg::PSR_PORT_IMPL)
	) u_port_reg (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_port),
		.wr_data(port_wdata),
		.cap_mask(capability_mask_four), // [R2] [R9] [R8]
		.value(port_ctrl)
	);

	// ************************************************************
	// reset request fields
	// ************************************************************
	localparam int PERIPH_UNITS = 7;

	logic [PERIPH_UNITS-1:0] periph_req;
	logic [PERIPH_UNITS-1:0] periph_rst;
	logic [PORT_COUNT-1:0] port_req;
	logic [PORT_COUNT-1:0] port_rst;

	assign periph_req[6] = periph_ctrl[psr_pkg::PSR_COMPARATOR_ONE_RESET_BIT]; // [R3]
	assign periph_req[5] = periph_ctrl[psr_pkg::PSR_COMPARATOR_ZERO_RESET_BIT]; // [R3]
	assign periph_req[4] = periph_ctrl[psr_pkg::PSR_GP_COUNTER_TWO_RESET_BIT]; // [R4]
	assign periph_req[3] = periph_ctrl[psr_pkg::PSR_GP_COUNTER_ONE_RESET_BIT]; // [R4]
	assign periph_req[2] = periph_ctrl[psr_pkg::PSR_GP_COUNTER_ZERO_RESET_BIT]; // [R4]
	assign periph_req[1] = periph_ctrl[psr_pkg::PSR_SYNC0_BIT]; // [R5]
	assign periph_req[0] = periph_ctrl[psr_pkg::PSR_ASYNC0_BIT]; // [R6]
	assign port_req = port_ctrl[psr_pkg::PSR_PORT_A_BIT +: PORT_COUNT]; // [R7]

	// ************************************************************
	// reset output stages
	// ************************************************************
	// registered so a decode glitch never pulses a peripheral reset
	psr_reset_stage #(
		.WIDTH(PERIPH_UNITS)
	) u_periph_stage (
		.pclk(pclk),
		.presetn(presetn),
		.req(periph_req),
		.rst_out(periph_rst) // [R10]
	);

	psr_reset_stage #(
		.WIDTH(PORT_COUNT)
	) u_port_stage (
		.pclk(pclk),
		.presetn(presetn),
		.req(port_req),
		.rst_out(port_rst) // [R10]
	);

	assign comparator_one_reset = periph_rst[6];
	assign comparator_zero_reset = periph_rst[5];
	assign gp_counter_two_reset = periph_rst[4];
	assign gp_counter_one_reset = periph_rst[3];
	assign gp_counter_zero_reset = periph_rst[2];
	assign sync_serial_zero_reset = periph_rst[1];
	assign async_serial_zero_reset = periph_rst[0];
	assign io_port_a_reset = port_rst[0];
	assign io_port_b_reset = port_rst[1];
	assign io_port_c_reset = port_rst[2];
	assign io_port_d_reset = port_rst[3];
	assign io_port_e_reset = port_rst[4];
	assign io_port_f_reset = port_rst[5];
	assign io_port_g_reset = port_rst[6];
	assign io_port_h_reset = port_rst[7];

	// ************************************************************
	// status views of the output stages
	// ************************************************************
	logic [31:0] periph_status;
	logic [31:0] port_status;

	// live output levels, so a read shows what the peripherals see
	always_comb begin
		periph_status = periph_place(periph_rst);
		port_status = port_place(port_rst);
	end

	// ************************************************************
	// read mux and response
	// ************************************************************
	logic [31:0] rd_sel;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;

	// reserved bits are zero in the stored value already
	assign rd_sel = hit_periph ? periph_ctrl : // [R9]
		hit_port ? port_ctrl :
		hit_periph_stat ? periph_status :
		hit_port_stat ? port_status :
		psr_pkg::PSR_READ_IDLE;

	// captured in setup so data leave a flop during access
	assign prdata_next = (setup_phase & ~pwrite) ? rd_sel : prdata_reg;
	assign pslverr_next = setup_phase ? ~hit_any : (access_phase & pslverr_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= psr_pkg::PSR_READ_IDLE;
			pslverr_reg <= 1'h0;
		end else begin
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & access_phase;
endmodule : psr_reset_ctrl

// [psr_reset_ctrl_monitor.sv]
// Purpose: port checks for the peripheral soft reset control
// Assumes: zero-wait apb; an output follows its register one edge late
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module psr_reset_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [31:0] capability_mask_two,
	input wire logic [31:0] capability_mask_four,
	input wire logic comparator_one_reset,
	input wire logic comparator_zero_reset,
	input wire logic gp_counter_zero_reset,
	input wire logic sync_serial_zero_reset,
	input wire logic async_serial_zero_reset,
	input wire logic io_port_a_reset,
	input wire logic io_port_h_reset
);
	// ****
	// access decode
	// ****
	wire acc = psel & penable;
	wire wa = acc & pwrite & (paddr == psr_pkg::PSR_PERIPH_RESET_OFF);
	wire wb = acc & pwrite & (paddr == psr_pkg::PSR_PORT_RESET_OFF);
	wire ra = acc & !pwrite & (paddr == psr_pkg::PSR_PERIPH_RESET_OFF);
	wire rb = acc & !pwrite & (paddr == psr_pkg::PSR_PORT_RESET_OFF);
	wire [31:0] c2 = capability_mask_two;
	wire [31:0] c4 = capability_mask_four;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_comp_one_set: assert property (
		wa & pstrb[3] & pwdata[25] & c2[25] |=> ##1 comparator_one_reset)
		else $error("comparator one reset not set");
	a_cap_two_gate: assert property (
		wa & !c2[24] & !comparator_zero_reset |=> ##1 !comparator_zero_reset)
		else $error("masked comparator bit was set");
	a_timer_follow: assert property (
		wa & pstrb[2] & c2[16] |=> ##1 gp_counter_zero_reset == $past(pwdata[16], 2))
		else $error("timer zero reset wrong");
	a_sync_follow: assert property (
		wa & pstrb[0] & c2[4] |=> ##1 sync_serial_zero_reset == $past(pwdata[4], 2))
		else $error("sync serial reset wrong");
	a_async_follow: assert property (
		wa & pstrb[0] & c2[0] |=> ##1 async_serial_zero_reset == $past(pwdata[0], 2))
		else $error("async serial reset wrong");
	a_port_follow: assert property (
		wb & pstrb[0] & c4[0] |=> ##1 io_port_a_reset == $past(pwdata[0], 2))
		else $error("port a reset wrong");
	a_cap_four_gate: assert property (
		wb & !c4[7] & !io_port_h_reset |=> ##1 !io_port_h_reset)
		else $error("masked port bit was set");
	a_reset_clears: assert property (disable iff (1'h0)
		$rose(presetn) |=> !comparator_one_reset && !io_port_h_reset)
		else $error("reset outputs not cleared");
	a_resv_zero: assert property (
		ra | rb |-> (prdata & ~(ra ? psr_pkg::PSR_PERIPH_IMPL : psr_pkg::PSR_PORT_IMPL)) == 32'h0)
		else $error("reserved bits not zero");
	c_write_a: cover property (wa);
	c_write_b: cover property (wb);
	c_error: cover property (acc & pslverr);
endmodule : psr_reset_ctrl_monitor
bind psr_reset_ctrl psr_reset_ctrl_monitor i_mon (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pslverr(pslverr),
	.capability_mask_two(capability_mask_two),
	.capability_mask_four(capability_mask_four),
	.comparator_one_reset(comparator_one_reset),
	.comparator_zero_reset(comparator_zero_reset),
	.gp_counter_zero_reset(gp_counter_zero_reset),
	.sync_serial_zero_reset(sync_serial_zero_reset),
	.async_serial_zero_reset(async_serial_zero_reset),
	.io_port_a_reset(io_port_a_reset),
	.io_port_h_reset(io_port_h_reset)
);

// [psr_reset_ctrl_tb.sv]
// Purpose: self-checking bench for the peripheral soft reset control
// Assumes: apb slave answers with pready; outputs follow a write one edge late
// Notes: bench drives every port itself, no random stimulus
`timescale 1ns/1ns
module psr_reset_ctrl_tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] cap2 = 32'hFFFF_FFFF;
	logic [31:0] cap4 = 32'hFFFF_FFFF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic c1, c0, t2, t1, t0, s0, a0;
	logic [7:0] io;
	logic [31:0] rd;
	logic er;
	int err_total = 0;
	int tests_run = 0;
	wire [31:0] pv = {6'h00, c1, c0, 5'h00, t2, t1, t0, 11'h000, s0, 3'h0, a0};
	wire [31:0] iv = {24'h0, io};
	always #5 pclk = ~pclk;
	psr_reset_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capability_mask_two(cap2),
		.capability_mask_four(cap4), .comparator_one_reset(c1), .comparator_zero_reset(c0),
		.gp_counter_two_reset(t2), .gp_counter_one_reset(t1), .gp_counter_zero_reset(t0),
		.sync_serial_zero_reset(s0), .async_serial_zero_reset(a0),
		.io_port_a_reset(io[0]), .io_port_b_reset(io[1]), .io_port_c_reset(io[2]),
		.io_port_d_reset(io[3]), .io_port_e_reset(io[4]), .io_port_f_reset(io[5]),
		.io_port_g_reset(io[6]), .io_port_h_reset(io[7]));
	// ****
	// shared tasks
	// ****
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			err_total++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task automatic settle;
		@(posedge pclk);
		#1;
	endtask : settle
	// ****
	// scenarios
	// ****
	task automatic test_reset;
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("outputs in reset", 32'h0307_0011, pv);
		presetn <= 1'h1;
		repeat (2) settle();
		chk("peripheral outputs", 32'h0, pv);
		chk("port outputs", 32'h0, iv);
		xfer(12'h044, 1'h0, 32'h0, 4'hF);
		chk("peripheral reg", 32'h0, rd);
		xfer(12'h048, 1'h0, 32'h0, 4'hF);
		chk("port reg", 32'h0, rd);
		$display("test_reset done");
	endtask : test_reset
	task automatic test_periph;
		int b[7] = '{25, 24, 18, 17, 16, 4, 0};
		foreach (b[i]) begin
			xfer(12'h044, 1'h1, 32'h1 << b[i], 4'hF);
			settle();
			chk("peripheral output", 32'h1 << b[i], pv);
			xfer(12'h044, 1'h0, 32'h0, 4'hF);
			chk("peripheral readback", 32'h1 << b[i], rd);
			xfer(12'h050, 1'h0, 32'h0, 4'hF);
			chk("peripheral status", 32'h1 << b[i], rd);
		end
		xfer(12'h044, 1'h1, 32'hFFFF_FFFF, 4'hF);
		xfer(12'h044, 1'h0, 32'h0, 4'hF);
		chk("reserved bits", 32'h0307_0011, rd);
		xfer(12'h044, 1'h1, 32'h0, 4'hF);
		settle();
		chk("release", 32'h0, pv);
		$display("test_periph done");
	endtask : test_periph
	task automatic test_cap;
		@(posedge pclk);
		cap2 <= 32'hFEFE_FFEF;
		xfer(12'h044, 1'h1, 32'hFFFF_FFFF, 4'hF);
		settle();
		chk("gated output", 32'h0206_0001, pv);
		xfer(12'h044, 1'h1, 32'h0, 4'hF);
		cap2 <= 32'hFFFF_FFFF;
		xfer(12'h044, 1'h1, 32'hFFFF_FFFF, 4'h4);
		xfer(12'h044, 1'h0, 32'h0, 4'hF);
		chk("byte lane", 32'h0007_0000, rd);
		xfer(12'h044, 1'h1, 32'h0, 4'hF);
		$display("test_cap done");
	endtask : test_cap
	task automatic test_port;
		for (int i = 0; i < 8; i++) begin
			xfer(12'h048, 1'h1, 32'h1 << i, 4'h1);
			settle();
			chk("port output", 32'h1 << i, iv);
			xfer(12'h048, 1'h0, 32'h0, 4'hF);
			chk("port readback", 32'h1 << i, rd);
			xfer(12'h054, 1'h0, 32'h0, 4'hF);
			chk("port status", 32'h1 << i, rd);
		end
		xfer(12'h048, 1'h1, 32'h0, 4'hF);
		cap4 <= 32'hFFFF_FF5A;
		xfer(12'h048, 1'h1, 32'hFFFF_FFFF, 4'hF);
		xfer(12'h048, 1'h0, 32'h0, 4'hF);
		chk("port gated", 32'h0000_005A, rd);
		cap4 <= 32'hFFFF_FFFF;
		$display("test_port done");
	endtask : test_port
	task automatic test_err;
		xfer(12'h100, 1'h1, 32'hFFFF_FFFF, 4'hF);
		chk("unmapped error", 32'h1, {31'h0, er});
		xfer(12'h100, 1'h0, 32'h0, 4'hF);
		chk("unmapped data", 32'h0, rd);
		xfer(12'h050, 1'h1, 32'hFFFF_FFFF, 4'hF);
		chk("status write error", 32'h0, {31'h0, er});
		xfer(12'h044, 1'h0, 32'h0, 4'hF);
		chk("untouched reg", 32'h0, rd);
		$display("test_err done");
	endtask : test_err
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		stop_test();
	end
	initial begin
		test_reset();
		test_periph();
		test_cap();
		test_port();
		test_err();
		xfer(12'h044, 1'h1, 32'hFFFF_FFFF, 4'hF);
		test_reset();
		stop_test();
	end
endmodule : psr_reset_ctrl_tb

// [psr_reset_stage.sv]
// Purpose: registered, glitch-free reset levels toward the peripherals
// Assumes: req is a level from the control registers on the same clock
// Notes: all resets asserted while system reset is low, then follow req
`timescale 1ns/1ns
module psr_reset_stage #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] req,
	output logic [WIDTH-1:0] rst_out
);
	logic [WIDTH-1:0] rst_reg;

	initial begin
		if (WIDTH < 1) begin
			$error("psr_reset_stage: WIDTH must be at least 1");
		end
	end

	assign rst_out = rst_reg;

	// peripherals stay in reset through system reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_reg <= '1;
		end else begin
			rst_reg <= req;
		end
	end
endmodule : psr_reset_stage
